//--- rtl/shared_bus_access_decoder.v
`timescale 1ns/1ps
`include "bus_share_defs.vh"
// decoder and arbiter for master access to the slave bus
module shared_bus_access_decoder (
  input wire core_clk,
  input wire rst_n,
  input wire slave_cpu_reset_n,
  input wire master_remote_request_n,
  input wire master_sync_n,
  input wire word_clock_enable_n,
  input wire slave_opcode_fetch_n,
  input wire slave_port_request_n,
  input wire slave_memory_request_n,
  input wire slave_addr_bit_twelve,
  output reg master_stall_n,
  output reg master_grant_n,
  output reg slave_stall_n,
  output reg ram_select_n,
  output reg dsp_store_select_n,
  output reg irq_acknowledge_n,
  output wire serial_chip_clock
);
  localparam ST_SLAVE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_GRANT = 3'b100;
  // grant window lengths and irq-ack lead in clock cycles
  localparam [2:0] REFRESH_WIN = `REFRESH_CYCLES; // R7
  localparam [2:0] IACK_WIN = `IACK_FETCH_T; // R9
  localparam [2:0] IACK_LEAD = `IACK_FETCH_T - `IACK_FREE_T; // R9

  // window length for a refresh grant or a late irq-ack grant
  function [2:0] grant_length;
    input from_iack;
    begin
      if (from_iack)
        grant_length = IACK_WIN;
      else
        grant_length = REFRESH_WIN;
    end
  endfunction

  // one step down, held at zero
  function [2:0] count_down;
    input [2:0] value;
    begin
      if (value != 3'h0)
        count_down = value - 3'h1;
      else
        count_down = 3'h0;
    end
  endfunction

  // one step up, held at the top so a stuck fetch cannot wrap
  function [2:0] count_up;
    input [2:0] value;
    begin
      if (value != 3'h7)
        count_up = value + 3'h1;
      else
        count_up = 3'h7;
    end
  endfunction

  // low-active select: low when a request is up and bit twelve matches
  function select_n;
    input any_request;
    input bit_twelve;
    input want_high;
    begin
      if (any_request)
        select_n = (bit_twelve != want_high);
      else
        select_n = 1'b1;
    end
  endfunction

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] win_q;
  reg [2:0] win_d;
  reg fetch_q;
  reg [2:0] low_cnt_q;
  reg sync_hold_q;
  wire req;
  wire refresh_start;
  wire late_iack;
  wire any_req;

  assign req = ~master_remote_request_n;
  // either side asking for the slave bus
  assign any_req = ~slave_memory_request_n | ~master_remote_request_n; // R1
  // refresh begins as the fetch strobe rises
  assign refresh_start = fetch_q & slave_opcode_fetch_n; // R7
  // last three t states of a long irq-ack fetch
  assign late_iack = ~slave_opcode_fetch_n &
    (low_cnt_q >= IACK_LEAD); // R9

  // track opcode-fetch low time
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_q <= 1'b0;
      low_cnt_q <= 3'h0;
    end else begin
      fetch_q <= ~slave_opcode_fetch_n;
      if (slave_opcode_fetch_n)
        low_cnt_q <= 3'h0;
      else
        low_cnt_q <= count_up(low_cnt_q);
    end
  end

  // master sync without word clock enable stalls the slave until its fetch with word clock enabled
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      sync_hold_q <= 1'b0;
    else if (!master_sync_n && word_clock_enable_n)
      sync_hold_q <= 1'b1;
    else if (!master_sync_n && !word_clock_enable_n && !slave_opcode_fetch_n)
      sync_hold_q <= 1'b0;
  end

  // arbitration state
  always @* begin
    state_d = state_q;
    win_d = 3'h0;
    case (state_q)
      // slave owns the bus
      ST_SLAVE: begin
        if (req && !slave_cpu_reset_n)
          state_d = ST_GRANT; // R4
        else if (req && (refresh_start || late_iack)) begin
          state_d = ST_GRANT; // R5
          win_d = grant_length(late_iack);
        end else if (req)
          state_d = ST_WAIT; // R8
      end
      // master stalled until a window opens
      ST_WAIT: begin
        if (!req)
          state_d = ST_SLAVE;
        else if (!slave_cpu_reset_n)
          state_d = ST_GRANT; // R4
        else if (refresh_start) begin
          state_d = ST_GRANT; // R10
          win_d = grant_length(1'b0);
        end
      end
      // master owns the bus for the window
      ST_GRANT: begin
        if (slave_cpu_reset_n) begin
          win_d = count_down(win_q);
          if (win_q <= 3'h1 && !late_iack)
            state_d = ST_SLAVE; // R10
        end
        // reset grant lasts while the request stays low
        if (!req && slave_cpu_reset_n == 1'b0)
          state_d = ST_SLAVE;
      end
      default: state_d = ST_SLAVE;
    endcase
  end

  // arbitration state register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      state_q <= ST_SLAVE;
    else
      state_q <= state_d;
  end

  // grant window counter
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      win_q <= 3'h0;
    else
      win_q <= win_d;
  end

  // master handshake strobes follow the next arbitration state
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_stall_n <= 1'b1;
      master_grant_n <= 1'b1;
    end else begin
      master_stall_n <= ~(state_d == ST_WAIT); // R2 R3
      master_grant_n <= ~(state_d == ST_GRANT); // R3 R10
    end
  end

  // slave stall from the word clock sync hold
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      slave_stall_n <= 1'b1;
    else
      slave_stall_n <= ~sync_hold_q;
  end

  // ram and dsp store selects from address bit twelve
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_select_n <= 1'b1;
      dsp_store_select_n <= 1'b1;
    end else begin
      ram_select_n <= select_n(any_req, slave_addr_bit_twelve, 1'b0); // R1 R6
      dsp_store_select_n <= select_n(any_req, slave_addr_bit_twelve, 1'b1); // R1 R6
    end
  end

  // irq acknowledge when fetch and port request are both low
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      irq_acknowledge_n <= 1'b1;
    else
      irq_acknowledge_n <= slave_opcode_fetch_n | slave_port_request_n; // R6
  end

  clock_divider #(
    .HALF(`SERIAL_DIV_HALF)
  ) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_out_q(serial_chip_clock)
  );
endmodule // shared_bus_access_decoder

//--- rtl/bus_share_defs.vh
// Notes on behaviour
// R1 - map shared ram and dsp store both sides
// R2 - master slave-bus access only in slave reset, refresh or irq-ack windows
// R3 - grant only in three situations, else wait
// R4 - slave reset held: grant at once
// R5 - otherwise grant in refresh or irq acknowledge
// R6 - bit twelve picks ram or store select
// R7 - slave gives two-cycle refresh each fetch
// R8 - misaligned request raises master wait
// R9 - late irq-ack request granted without waits
// R10 - grant at window start, release at end
`ifndef BUS_SHARE_DEFS_VH
`define BUS_SHARE_DEFS_VH
`define CLK_RATE_HZ 10000000
`define REFRESH_CYCLES 3'h2
`define IACK_FETCH_T 3'h4
`define IACK_FREE_T 3'h3
`define SERIAL_DIV_HALF 2
`endif

//--- rtl/clock_divider.v
`timescale 1ns/1ps
// serial chip clock from the processor clock domain
module clock_divider #(
  parameter HALF = 2
) (
  input wire core_clk,
  input wire rst_n,
  output reg clk_out_q
);
  reg [7:0] cnt_q;

  // toggle output every half period
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      clk_out_q <= 1'b0;
    end else if (cnt_q == HALF[7:0] - 8'h01) begin
      cnt_q <= 8'h00;
      clk_out_q <= ~clk_out_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // clock_divider

//--- verif/bus_access_checker_properties.sv
`timescale 1ns/1ps
// arbiter and decode checks
module bus_access_checker (
  input wire core_clk,
  input wire rst_n,
  input wire slave_cpu_reset_n,
  input wire master_remote_request_n,
  input wire slave_opcode_fetch_n,
  input wire slave_memory_request_n,
  input wire slave_addr_bit_twelve,
  input wire master_stall_n,
  input wire master_grant_n,
  input wire ram_select_n,
  input wire dsp_store_select_n
);
  // short names
  wire s = slave_cpu_reset_n;
  wire r = master_remote_request_n;
  wire f = slave_opcode_fetch_n;
  wire g = master_grant_n;
  wire w = master_stall_n;
  wire q = !slave_memory_request_n || !r;
  wire b = slave_addr_bit_twelve;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence win_s;
    !g && w ##1 !g ##1 g;
  endsequence
  ram_sel_a: assert property (q && !b |=> !ram_select_n) else $error("ram");
  dsp_sel_a: assert property (q && b |=> !dsp_store_select_n) else $error("dsp");
  no_sel_a: assert property (!q |=> ram_select_n && dsp_store_select_n) else $error("idle");
  rst_grant_a: assert property (!s && !r |=> !g && w) else $error("reset");
  early_stall_a: assert property (s && g && $fell(r) && f && $past(f) && $past(f, 2)
    |=> !w) else $error("stall");
  late_ack_a: assert property (s && $fell(r) && !f && !$past(f)
    |=> w ##[0:4] !g) else $error("late");
  win_grant_a: assert property (s && !r && $rose(f) && $past(f, 3) |=> win_s) else $error("win");
  grant_cause_a: assert property ($fell(g) |-> !$past(r)) else $error("cause");
endmodule // bus_access_checker
bind shared_bus_access_decoder bus_access_checker i_bus_access_checker (.*);

//--- verif/slave_cpu_model.sv
`timescale 1ns/1ps
// slave cpu: fetch, two-cycle refresh, optional irq acknowledge
module slave_cpu_model (
  input wire core_clk,
  input wire iack_mode,
  output reg slave_opcode_fetch_n = 1'b1,
  output reg slave_port_request_n = 1'b1
);
  reg [2:0] t_q = 3'h0;
  // steps on the falling edge
  always @(negedge core_clk) begin
    t_q <= t_q + 3'h1;
    slave_opcode_fetch_n <= t_q > (iack_mode ? 3'h3 : 3'h1);
    slave_port_request_n <= !(iack_mode && t_q[2:1] == 2'h1);
  end
endmodule // slave_cpu_model

//--- verif/shared_bus_access_decoder_test.sv
`timescale 1ns/1ps
module shared_bus_access_decoder_test;
  reg core_clk = 1'b0, rst_n = 1'b0, slave_cpu_reset_n = 1'b1, master_remote_request_n = 1'b1;
  reg master_sync_n = 1'b1, word_clock_enable_n = 1'b1, slave_memory_request_n = 1'b1;
  reg slave_addr_bit_twelve = 1'b0, iack_mode = 1'b0;
  wire slave_opcode_fetch_n, slave_port_request_n, master_stall_n, master_grant_n, slave_stall_n;
  wire ram_select_n, dsp_store_select_n, irq_acknowledge_n, serial_chip_clock;
  integer fail_count = 0, checked = 0, cyc = 0, i;
  reg [4:0] sv;
  shared_bus_access_decoder i_shared_bus_access_decoder (.*);
  slave_cpu_model i_slave_cpu_model (.*);
  initial forever #50 core_clk = ~core_clk;
  task chk(input string n, input logic [1:0] e, v);
    checked++;
    if (v !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", n, e, v);
    end
  endtask
  task results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang ceiling
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      results;
    end
  end
  // slave held in reset
  task t_rst;
    @(negedge core_clk) {slave_cpu_reset_n, master_remote_request_n} = 2'h0;
    @(negedge core_clk) chk("rst", 2'h1, {master_grant_n, master_stall_n});
    {slave_cpu_reset_n, master_remote_request_n} = 2'h3;
    repeat (2) @(negedge core_clk);
  endtask
  // request outside refresh waits
  task t_win;
    @(posedge slave_opcode_fetch_n) repeat (3) @(negedge core_clk);
    master_remote_request_n = 1'b0;
    @(negedge core_clk) chk("wait", 2'h2, {master_grant_n, master_stall_n});
    @(posedge slave_opcode_fetch_n) @(negedge core_clk);
    chk("open", 2'h1, {master_grant_n, master_stall_n});
    master_remote_request_n = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("shut", 2'h3, {master_grant_n, master_stall_n});
  endtask
  // late request in irq acknowledge
  task t_iack;
    @(negedge slave_opcode_fetch_n) iack_mode = 1'b1;
    @(negedge core_clk) {master_remote_request_n, slave_addr_bit_twelve} = 2'h1;
    @(negedge core_clk) chk("late", 2'h3, {1'b1, master_stall_n});
    @(negedge core_clk) chk("ack", 2'h2, {1'b1, irq_acknowledge_n});
    for (i = 0; i < 4 && master_grant_n !== 1'b0; i++) @(negedge core_clk);
    chk("grant", 2'h2, {1'b1, master_grant_n});
    master_remote_request_n = 1'b1;
    @(posedge slave_opcode_fetch_n) iack_mode = 1'b0;
  endtask
  // slave-side select, sync hold and serial clock
  task t_side;
    @(negedge core_clk) {slave_memory_request_n, slave_addr_bit_twelve} = 2'h0;
    @(negedge core_clk) chk("ram", 2'h1, {ram_select_n, dsp_store_select_n});
    slave_memory_request_n = 1'b1;
    master_sync_n = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("hold", 2'h2, {1'b1, slave_stall_n}); // sync
    word_clock_enable_n = 1'b0;
    @(negedge slave_opcode_fetch_n) repeat (3) @(negedge core_clk);
    chk("free", 2'h3, {1'b1, slave_stall_n}); // sync
    {master_sync_n, word_clock_enable_n} = 2'h3;
    for (i = 0; i < 5; i++) begin
      @(negedge core_clk) sv[i] = serial_chip_clock;
    end
    chk("serial_chip_clock", ~sv[1:0], sv[3:2]); // divider
    chk("uclk4", {1'b0, sv[0]}, {1'b0, sv[4]}); // divider
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    t_rst;
    t_win;
    t_iack;
    t_side;
    results;
  end
endmodule // shared_bus_access_decoder_test
